// File: design/upsc_pkg.sv
// package: register map, field positions, reset values and timing for usb power/suspend control
package upsc_pkg;

  // register map: one 32-bit control/status word on the avalon slave
  localparam logic [3:0] UPSC_ADDR_W = 4'h4;
  localparam logic [UPSC_ADDR_W-1:0] UPSC_OFS_POWER_SUSPEND_CTRL = 4'h0;

  // field positions inside usb_power_suspend_ctrl
  localparam int UPSC_BIT_MODULE_POWER_ON = 0;
  localparam int UPSC_BIT_SUSPEND_REQUEST = 1;
  localparam int UPSC_BIT_MODULE_BUSY = 3;
  localparam int UPSC_BIT_SLEEP_ENTRY_GUARD = 4;
  localparam int UPSC_BIT_ACTIVITY_PENDING = 7;

  // reset values of the implemented bits
  localparam logic UPSC_RST_MODULE_POWER_ON = 1'b0;
  localparam logic UPSC_RST_SUSPEND_REQUEST = 1'b0;
  localparam logic UPSC_RST_SLEEP_ENTRY_GUARD = 1'b0;
  localparam logic UPSC_RST_ACTIVITY_PENDING = 1'b0;

  // unmapped addresses and unimplemented bits read as this
  localparam logic [31:0] UPSC_READ_ZERO = 32'h0000_0000;

  // clock rate and the analog shutdown settling time after power-off
  localparam int UPSC_CLK_PERIOD_PS = 5000;
  localparam int UPSC_SETTLE_TIME_NS = 1000;
  // least time, so round up to whole cycles
  localparam int UPSC_SETTLE_CYCLES =
    (UPSC_SETTLE_TIME_NS * 1000 + UPSC_CLK_PERIOD_PS - 1) / UPSC_CLK_PERIOD_PS;
  localparam int UPSC_SETTLE_CNT_W = 8;

  // software-writable control bits
  typedef struct packed {
    logic sleep_entry_guard;
    logic suspend_request;
    logic module_power_on;
  } upsc_ctrl_t;

  // drive towards the usb core, transceiver and pin mux
  typedef struct packed {
    logic usb_clk_enable;
    logic transceiver_on;
    logic transceiver_low_power;
    logic pins_claimed;
    logic outputs_active;
  } upsc_usb_drive_t;

endpackage : upsc_pkg

// File: design/upsc_busy_tracker.sv
// busy tracker: holds busy while powered and until shutdown has settled after power-off
`timescale 1ns/1ps
module upsc_busy_tracker
  import upsc_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic module_power_on_i,
  output logic module_busy_o
);

  logic [UPSC_SETTLE_CNT_W-1:0] settle_count;
  logic [UPSC_SETTLE_CNT_W-1:0] next_settle_count;
  logic settling;

  // reload while powered, count down after power-off until ready again
  assign settling = (settle_count != '0);
  assign next_settle_count = module_power_on_i ? UPSC_SETTLE_CYCLES[UPSC_SETTLE_CNT_W-1:0] :
                             settling ? settle_count - 1'b1 : settle_count;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      settle_count <= '0;
    end else begin
      settle_count <= next_settle_count;
    end
  end

  // active, or disabled but not yet ready to be re-enabled
  assign module_busy_o = module_power_on_i | settling;

endmodule : upsc_busy_tracker

// File: design/upsc_power_suspend.sv
// usb power and suspend control: avalon-mm register slave and power sequencing
`timescale 1ns/1ps
// Summary of operation
// - bit 7 flags bus activity seen whose interrupt is not yet raised; else zero.
// - guard bit 4 set blocks sleep on bus activity or pending notice.
// - busy bit 3 is one while active or disabled and not yet ready.
// - suspend bit 1 gates the 48 MHz clock and idles the transceiver.
// - power bit 0 turns module on; off holds outputs, frees pins, stops analog.
// - unimplemented bits read zero; implemented bits are zero after power-on.
module upsc_power_suspend
  import upsc_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  // avalon-mm slave
  input wire logic [UPSC_ADDR_W-1:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  // usb side
  input wire logic usb_bus_activity_i,
  output logic usb_activity_irq_o,
  output logic usb_clk_enable_o,
  output logic transceiver_on_o,
  output logic transceiver_low_power_o,
  output logic pins_claimed_o,
  output logic outputs_active_o,
  // system power manager
  output logic sleep_block_o
);

  // control bits and status flags
  upsc_ctrl_t ctrl;
  upsc_ctrl_t next_ctrl;
  logic activity_pending_flag;
  logic next_activity_pending_flag;
  logic module_busy_flag;
  upsc_usb_drive_t usb_drive;
  upsc_usb_drive_t next_usb_drive;
  logic irq_pulse;

  // bus handshake state
  logic bus_ack;
  logic [31:0] read_word;

  // decode and handshake wires
  logic bus_request;
  logic addr_hit;
  logic write_fire;
  logic write_low_lane;
  logic [31:0] reg_view;
  logic [31:0] next_read_word;

  // bus activity and interrupt generation
  logic activity_seen;
  logic irq_generate;

  //--------------------------------------------------------------------------
  // avalon-mm slave: one wait cycle, then the answer
  //--------------------------------------------------------------------------

  // a request is answered in the cycle after it appears
  assign bus_request = read_i | write_i;
  assign waitrequest_o = bus_request & ~bus_ack;

  // address decode: only the control word is mapped
  assign addr_hit = (address_i == UPSC_OFS_POWER_SUSPEND_CTRL);

  // a write takes effect at the edge where waitrequest is seen low
  assign write_fire = write_i & bus_ack & addr_hit;
  // all implemented bits live in byte lane 0
  assign write_low_lane = write_fire & byteenable_i[0];

  // ack toggles high for exactly one cycle per request
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= bus_request & ~bus_ack;
    end
  end

  //--------------------------------------------------------------------------
  // register view
  //--------------------------------------------------------------------------

  // assemble the readable word; every other bit stays zero
  always_comb begin
    reg_view = UPSC_READ_ZERO;
    reg_view[UPSC_BIT_MODULE_POWER_ON] = ctrl.module_power_on;
    reg_view[UPSC_BIT_SUSPEND_REQUEST] = ctrl.suspend_request;
    reg_view[UPSC_BIT_MODULE_BUSY] = module_busy_flag;
    reg_view[UPSC_BIT_SLEEP_ENTRY_GUARD] = ctrl.sleep_entry_guard;
    reg_view[UPSC_BIT_ACTIVITY_PENDING] = activity_pending_flag;
  end

  // unmapped addresses return zero
  assign next_read_word = (read_i & ~bus_ack & addr_hit) ? reg_view :
                          (read_i & ~bus_ack) ? UPSC_READ_ZERO : read_word;

  // read data is captured in the wait cycle and stands while waitrequest is low
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      read_word <= UPSC_READ_ZERO;
    end else begin
      read_word <= next_read_word;
    end
  end

  assign readdata_o = read_word;

  //--------------------------------------------------------------------------
  // control bits
  //--------------------------------------------------------------------------

  // software writes power, suspend and guard; busy and pending are read-only
  always_comb begin
    next_ctrl = ctrl;
    if (write_low_lane) begin
      next_ctrl.module_power_on = writedata_i[UPSC_BIT_MODULE_POWER_ON];
      next_ctrl.suspend_request = writedata_i[UPSC_BIT_SUSPEND_REQUEST];
      next_ctrl.sleep_entry_guard = writedata_i[UPSC_BIT_SLEEP_ENTRY_GUARD];
    end
  end

  // all control bits clear at reset
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl.module_power_on <= UPSC_RST_MODULE_POWER_ON;
      ctrl.suspend_request <= UPSC_RST_SUSPEND_REQUEST;
      ctrl.sleep_entry_guard <= UPSC_RST_SLEEP_ENTRY_GUARD;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  //--------------------------------------------------------------------------
  // busy tracking
  //--------------------------------------------------------------------------

  // busy stays up after power-off until the analog side has shut down;
  // software waits for it to drop before powering up again
  upsc_busy_tracker u_busy_tracker (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .module_power_on_i(ctrl.module_power_on),
    .module_busy_o(module_busy_flag)
  );

  //--------------------------------------------------------------------------
  // power and suspend drive
  //--------------------------------------------------------------------------

  // power off releases everything; suspend keeps pins but stops the clock
  always_comb begin
    next_usb_drive.pins_claimed = next_ctrl.module_power_on;
    next_usb_drive.outputs_active = next_ctrl.module_power_on;
    next_usb_drive.transceiver_on = next_ctrl.module_power_on;
    next_usb_drive.usb_clk_enable =
      next_ctrl.module_power_on & ~next_ctrl.suspend_request;
    next_usb_drive.transceiver_low_power =
      next_ctrl.module_power_on & next_ctrl.suspend_request;
  end

  // drive outputs come from flops, tracking the control bits
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      usb_drive <= '0;
    end else begin
      usb_drive <= next_usb_drive;
    end
  end

  assign usb_clk_enable_o = usb_drive.usb_clk_enable;
  assign transceiver_on_o = usb_drive.transceiver_on;
  assign transceiver_low_power_o = usb_drive.transceiver_low_power;
  assign pins_claimed_o = usb_drive.pins_claimed;
  assign outputs_active_o = usb_drive.outputs_active;

  //--------------------------------------------------------------------------
  // bus activity and its interrupt
  //--------------------------------------------------------------------------

  // activity only counts while the module owns the pins
  assign activity_seen = usb_bus_activity_i & ctrl.module_power_on;

  // the interrupt can only be generated while the usb clock runs
  assign irq_generate = activity_pending_flag & usb_drive.usb_clk_enable;

  // new activity in the generating cycle keeps the flag set
  assign next_activity_pending_flag =
    activity_seen | (activity_pending_flag & ~irq_generate);

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      activity_pending_flag <= UPSC_RST_ACTIVITY_PENDING;
      irq_pulse <= 1'b0;
    end else begin
      activity_pending_flag <= next_activity_pending_flag;
      irq_pulse <= irq_generate;
    end
  end

  assign usb_activity_irq_o = irq_pulse;

  //--------------------------------------------------------------------------
  // sleep entry guard
  //--------------------------------------------------------------------------

  // block sleep only when the guard is set and something is happening
  assign sleep_block_o = ctrl.sleep_entry_guard &
                         (usb_bus_activity_i | activity_pending_flag);

endmodule : upsc_power_suspend

// File: sim/upsc_power_suspend_props.sv
// checker: port-level properties of usb power and suspend control
`timescale 1ns/1ps
module upsc_power_suspend_props (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] readdata_o,
  input wire logic waitrequest_o,
  input wire logic usb_bus_activity_i,
  input wire logic usb_activity_irq_o,
  input wire logic usb_clk_enable_o,
  input wire logic transceiver_on_o,
  input wire logic transceiver_low_power_o,
  input wire logic pins_claimed_o,
  input wire logic outputs_active_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // a read is answered in this cycle
  wire rd_done = read_i && !waitrequest_o;
  a_power_outputs_tied: assert property (pins_claimed_o == transceiver_on_o
    && outputs_active_o == transceiver_on_o) else $error("power outputs disagree");
  a_gate_needs_power: assert property (usb_clk_enable_o |-> transceiver_on_o
    && !transceiver_low_power_o) else $error("clock gate on while off or suspended");
  // a second pulse right after the first needs fresh activity that re-set the flag
  a_irq_single_pulse: assert property (usb_activity_irq_o |=> !usb_activity_irq_o
    || $past(usb_bus_activity_i, 2)) else $error("activity interrupt longer than one cycle");
  a_irq_needs_clock: assert property (usb_activity_irq_o |-> $past(usb_clk_enable_o))
    else $error("activity interrupt without usb clock");
  a_activity_to_irq: assert property ((usb_bus_activity_i && usb_clk_enable_o)
    ##1 usb_clk_enable_o |-> ##1 usb_activity_irq_o) else $error("activity not reported");
  a_unimpl_read_zero: assert property (rd_done |-> readdata_o[31:8] == 24'h0
    && readdata_o[6:5] == 2'h0 && !readdata_o[2]) else $error("unimplemented bit set");
  a_busy_while_on: assert property (rd_done && readdata_o[0] |-> readdata_o[3])
    else $error("busy clear while powered");
  a_wait_one_cycle: assert property ((read_i || write_i) && waitrequest_o
    |=> !waitrequest_o) else $error("request not answered after one wait state");
endmodule : upsc_power_suspend_props
bind upsc_power_suspend upsc_power_suspend_props upsc_power_suspend_props_i (
  .clock_i(clock_i), .resetn_i(resetn_i), .read_i(read_i), .write_i(write_i),
  .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
  .usb_bus_activity_i(usb_bus_activity_i), .usb_activity_irq_o(usb_activity_irq_o),
  .usb_clk_enable_o(usb_clk_enable_o), .transceiver_on_o(transceiver_on_o),
  .transceiver_low_power_o(transceiver_low_power_o), .pins_claimed_o(pins_claimed_o),
  .outputs_active_o(outputs_active_o));

// File: sim/upsc_bus_partner.sv
// partner: usb bus activity as reported by the transceiver
`timescale 1ns/1ps
module upsc_bus_partner (
  input wire logic clock_i,
  output logic activity_o
);
  initial activity_o = 1'b0;
  // change the activity level just after a rising edge
  task automatic drive(input logic v);
    @(posedge clock_i);
    activity_o <= v;
  endtask : drive
endmodule : upsc_bus_partner

// File: sim/upsc_power_suspend_bench.sv
// bench: register access, power sequencing and activity reporting
`timescale 1ns/1ps
module upsc_power_suspend_bench;
  import upsc_pkg::*;
  logic clock_i, resetn_i, read_i, write_i, act, irq, clk_en, xon, lowp, pins, outs, slp;
  logic wreq, s, g;
  logic [UPSC_ADDR_W-1:0] addr;
  logic [31:0] wdata, rdata, q, d;
  logic [3:0] be, bb, aa;
  int fails = 0;
  int checked = 0;
  int irqs = 0;
  upsc_power_suspend upsc_power_suspend_i (.clock_i(clock_i), .resetn_i(resetn_i),
    .address_i(addr), .read_i(read_i), .write_i(write_i), .writedata_i(wdata),
    .byteenable_i(be), .readdata_o(rdata), .waitrequest_o(wreq),
    .usb_bus_activity_i(act), .usb_activity_irq_o(irq), .usb_clk_enable_o(clk_en),
    .transceiver_on_o(xon), .transceiver_low_power_o(lowp), .pins_claimed_o(pins),
    .outputs_active_o(outs), .sleep_block_o(slp));
  upsc_bus_partner upsc_bus_partner_i (.clock_i(clock_i), .activity_o(act));
  // 200 mhz clock
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  // count interrupt pulses
  always @(posedge clock_i) if (irq === 1'b1) irqs <= irqs + 1;
  // expected register word from its fields
  function automatic logic [31:0] regw(logic p, logic u, logic k, logic b, logic a);
    return {24'h0, a, 2'h0, k, b, 1'h0, u, p};
  endfunction : regw
  task automatic chk(string n, logic [31:0] e, logic [31:0] v);
    checked++;
    if (v !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, v);
    end
  endtask : chk
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(logic w, logic [3:0] a, logic [31:0] v, logic [3:0] b);
    @(posedge clock_i);
    addr <= a;
    wdata <= v;
    be <= b;
    write_i <= w;
    read_i <= !w;
    do @(posedge clock_i); while (wreq !== 1'b0);
    q = rdata;
    write_i <= 1'b0;
    read_i <= 1'b0;
  endtask : bus
  task automatic rdc(logic [3:0] a, logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf);
    chk("readdata", e, q);
  endtask : rdc
  task automatic mid(int n);
    repeat (n) @(posedge clock_i);
    @(negedge clock_i);
  endtask : mid
  task automatic results();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  // watchdog against a hung handshake
  initial begin
    repeat (3000) @(posedge clock_i);
    fails++;
    results();
  end
  // main sequence
  initial begin
    {resetn_i, read_i, write_i, addr, wdata, be} = '0;
    d = $urandom(79441);
    repeat (2) @(posedge clock_i);
    resetn_i <= 1'b1;
    rdc(4'h0, 32'h0);
    bus(1'b1, 4'h0, 32'hffff_ffff, 4'he);
    bus(1'b1, 4'h4, 32'hffff_ffff, 4'hf);
    rdc(4'h4, 32'h0);
    rdc(4'h0, 32'h0);
    d = $urandom;
    bus(1'b1, 4'h0, {d[31:5], 5'h11}, 4'hf);
    rdc(4'h0, regw(1, 0, 1, 1, 0));
    mid(3);
    chk("drive", 32'h1f, {27'h0, xon, pins, outs, clk_en, !lowp});
    upsc_bus_partner_i.drive(1'b1);
    @(negedge clock_i);
    chk("sleep", 32'h1, {31'h0, slp});
    upsc_bus_partner_i.drive(1'b0);
    mid(4);
    chk("irqs", 32'h1, irqs);
    rdc(4'h0, regw(1, 0, 1, 1, 0));
    {s, g} = 2'b01;
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      d[0] = 1'b1;
      bb = 4'($urandom);
      aa = 4'($urandom) & 4'h4; // mapped word or an unmapped one
      bus(1'b1, aa, d, bb);
      if (bb[0] && aa == 4'h0) {s, g} = {d[1], d[4]};
      rdc(aa, (aa == 4'h0) ? regw(1, s, g, 1, 0) : 32'h0);
      rdc(4'h0, regw(1, s, g, 1, 0));
    end
    bus(1'b1, 4'h0, 32'h13, 4'h1);
    mid(3);
    chk("drive", 32'h1c, {27'h0, xon, pins, outs, clk_en, !lowp});
    upsc_bus_partner_i.drive(1'b1);
    upsc_bus_partner_i.drive(1'b0);
    mid(4);
    chk("sleep", 32'h1, {31'h0, slp});
    rdc(4'h0, regw(1, 1, 1, 1, 1));
    bus(1'b1, 4'h0, 32'h11, 4'h1);
    mid(6);
    chk("irqs", 32'h2, irqs);
    rdc(4'h0, regw(1, 0, 1, 1, 0));
    bus(1'b1, 4'h0, 32'h1, 4'h1);
    upsc_bus_partner_i.drive(1'b1);
    @(negedge clock_i);
    chk("sleep", 32'h0, {31'h0, slp});
    upsc_bus_partner_i.drive(1'b0);
    mid(4);
    bus(1'b1, 4'h0, 32'h0, 4'h1);
    rdc(4'h0, regw(0, 0, 0, 1, 0));
    mid(3);
    chk("drive", 32'h1, {27'h0, xon, pins, outs, clk_en, !lowp});
    repeat (UPSC_SETTLE_CYCLES - 20) @(posedge clock_i);
    rdc(4'h0, regw(0, 0, 0, 1, 0));
    repeat (40) @(posedge clock_i);
    rdc(4'h0, 32'h0);
    results();
  end
endmodule : upsc_power_suspend_bench
